// File: spi_port_pkg.sv
package spi_port_pkg;

	// ==========================================================
	// Register map, byte addresses on the APB
	localparam logic [7:0] CTRL_ADDR = 8'h90;
	localparam logic [7:0] STAT_ADDR = 8'h94;
	localparam logic [7:0] DATA_ADDR = 8'h98;
	localparam logic [7:0] EVT_ADDR = 8'h9C;
	localparam logic [7:0] MASK_ADDR = 8'hA0;

	// ==========================================================
	// Control register fields (low six bits)
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_CPOL = 4;
	localparam int CTRL_EN = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
	localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
	localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
	localparam logic [3:0] MODE_SLAVE_SS = 4'h4;
	localparam logic [3:0] MODE_SLAVE_NOSS = 4'h5;

	// ==========================================================
	// Status register fields (top two bits writable)
	localparam int STAT_PHASE = 7;
	localparam int STAT_CKE = 6;
	localparam int STAT_FULL = 0;
	localparam logic [7:0] STAT_RESET = 8'h00;

	// ==========================================================
	// Event bits: done, overrun, write collision
	localparam int EVT_W = 3;
	localparam int EVT_DONE = 0;
	localparam int EVT_OVR = 1;
	localparam int EVT_COL = 2;

	// ==========================================================
	// Frame and timing: half periods of the master clock in pclk
	localparam logic [3:0] FRAME_BITS = 4'h8;
	localparam logic [4:0] FRAME_EDGES = 5'h10;
	localparam logic [5:0] HALF_DIV4 = 6'h02;
	localparam logic [5:0] HALF_DIV16 = 6'h08;
	localparam logic [5:0] HALF_DIV64 = 6'h20;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHIFT = 2'b01
	} mode_t;

endpackage : spi_port_pkg

// File: pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins in, synchronised out
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] stage1;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= RESET_VAL;
			pin_out <= RESET_VAL;
		end else begin
			stage1 <= pin_in;
			pin_out <= stage1;
		end
	end

endmodule : pin_sync

// File: spi_port.sv
`timescale 1ns/1ns
module spi_port (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial pins
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire logic ss_n,
	// Interrupt
	output logic irq
);
	import spi_port_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		mode_t mode;
		logic [5:0] ctrl;
		logic phase;
		logic cke;
		logic full;
		logic [1:0] cap_dly;
		logic [1:0] fin_dly;
		logic [7:0] rx_buf;
		logic [7:0] tx_hold;
		logic [7:0] tx_sh;
		logic [7:0] rx_sh;
		logic [3:0] bit_cnt;
		logic [4:0] edge_cnt;
		logic [5:0] div_cnt;
		logic sck_out;
		logic sck_oe;
		logic sdo;
		logic sdo_oe;
		logic sck_prev;
		logic [EVT_W-1:0] evt;
		logic [EVT_W-1:0] mask;
		logic irq;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} state_t;

	state_t s;
	state_t next_s;
	logic [2:0] sync_q;
	logic sck_s;
	logic sdi_s;
	logic ss_n_s;

	// Pins from the far side pass two flops before use
	// Select idles high, so it leaves reset deselected
	pin_sync #(.WIDTH(3), .RESET_VAL(3'h4)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in({ss_n, sdi, sck_in}),
		.pin_out(sync_q)
	);
	assign sck_s = sync_q[0];
	assign sdi_s = sync_q[1];
	assign ss_n_s = sync_q[2];

	// ==========================================================
	// Decode
	logic en;
	logic master;
	logic slave;
	logic use_ss;
	logic [5:0] half;
	logic access;
	logic wr_fire;
	logic rd_fire;
	logic done;

	always_comb begin
		en = s.ctrl[CTRL_EN];
		master = en && s.ctrl[3:0] inside {MODE_MASTER_DIV4,
			MODE_MASTER_DIV16, MODE_MASTER_DIV64};
		slave = en && s.ctrl[3:0] inside {MODE_SLAVE_SS, MODE_SLAVE_NOSS};
		use_ss = s.ctrl[3:0] == MODE_SLAVE_SS;
		case (s.ctrl[1:0])
			2'b00: half = HALF_DIV4;
			2'b01: half = HALF_DIV16;
			default: half = HALF_DIV64;
		endcase
		access = psel && penable;
		wr_fire = access && s.pready && pwrite;
		rd_fire = access && s.pready && !pwrite;
	end

	// ==========================================================
	// Next state
	always_comb begin
		logic cap;
		logic chg;
		logic fin;
		logic mcap;
		logic mfin;
		logic lead;
		logic sel;
		logic [EVT_W-1:0] set;
		logic [EVT_W-1:0] clr;
		logic [31:0] rd;
		logic hit;
		cap = 1'b0;
		chg = 1'b0;
		fin = 1'b0;
		mcap = 1'b0;
		mfin = 1'b0;
		lead = 1'b0;
		sel = 1'b0;
		set = '0;
		clr = '0;
		rd = '0;
		hit = 1'b1;
		next_s = s;

		// APB: one wait state, effects at the sampled ready edge
		case (paddr)
			CTRL_ADDR: rd = {26'h0, s.ctrl};
			STAT_ADDR: rd = {24'h0, s.phase, s.cke, 5'h00, s.full};
			DATA_ADDR: rd = {24'h0, s.rx_buf};
			EVT_ADDR: rd = {29'h0, s.evt};
			MASK_ADDR: rd = {29'h0, s.mask};
			default: hit = 1'b0;
		endcase
		next_s.pready = access && !s.pready;
		if (access && !s.pready) begin
			next_s.prdata = pwrite ? 32'h0 : rd;
			next_s.pslverr = !hit;
		end
		if (wr_fire) begin
			case (paddr)
				CTRL_ADDR: next_s.ctrl = pwdata[5:0];
				STAT_ADDR: begin
					next_s.phase = pwdata[STAT_PHASE];
					next_s.cke = pwdata[STAT_CKE];
				end
				MASK_ADDR: next_s.mask = pwdata[EVT_W-1:0];
				default: ;
			endcase
		end
		if (rd_fire && paddr == EVT_ADDR)
			clr = s.evt;

		// Shift engine
		sel = !use_ss || !ss_n_s;
		next_s.sck_prev = sck_s;
		next_s.sck_oe = master;
		next_s.sdo_oe = master || (slave && sel);
		if (!en) begin
			next_s.mode = ST_IDLE;
			next_s.bit_cnt = '0;
			next_s.sck_out = s.ctrl[CTRL_CPOL];
		end else if (master) begin
			case (s.mode)
				ST_IDLE: begin
					next_s.sck_out = s.ctrl[CTRL_CPOL];
					if (wr_fire && paddr == DATA_ADDR
						&& s.fin_dly == 2'b00) begin
						next_s.mode = ST_SHIFT;
						next_s.div_cnt = '0;
						next_s.edge_cnt = '0;
						next_s.bit_cnt = '0;
						if (s.cke) begin
							next_s.tx_sh = pwdata[7:0];
						end else begin
							next_s.sdo = pwdata[7];
							next_s.tx_sh = {pwdata[6:0], 1'b0};
						end
					end
				end
				ST_SHIFT: begin
					next_s.div_cnt = s.div_cnt + 6'h01;
					if (s.div_cnt == half - 6'h01) begin
						next_s.div_cnt = '0;
						next_s.edge_cnt = s.edge_cnt + 5'h01;
						if (s.edge_cnt != FRAME_EDGES) begin
							next_s.sck_out = !s.sck_out;
							lead = !s.edge_cnt[0];
							// Change edge: leading when the edge bit is set
							chg = lead == s.cke;
							// End sampling reads just before the change
							mcap = chg ? (s.phase && !(s.cke && s.edge_cnt == 5'h00))
								: !s.phase;
						end else begin
							mcap = s.cke && s.phase;
							mfin = 1'b1;
							next_s.mode = ST_IDLE;
						end
					end
				end
				default: next_s.mode = ST_IDLE;
			endcase
		end else if (slave) begin
			// Far master clocks us; sampling is always mid bit
			next_s.mode = ST_IDLE;
			next_s.sck_out = s.ctrl[CTRL_CPOL];
			if (!sel) begin
				next_s.bit_cnt = '0;
				next_s.tx_sh = s.cke ? s.tx_hold : {s.tx_hold[6:0], 1'b0};
				if (!s.cke)
					next_s.sdo = s.tx_hold[7];
			end else if (sck_s != s.sck_prev) begin
				lead = sck_s != s.ctrl[CTRL_CPOL];
				chg = lead == s.cke;
				cap = !chg;
				fin = !chg && s.bit_cnt == FRAME_BITS - 4'h1;
			end
			if (wr_fire && paddr == DATA_ADDR) begin
				if (s.bit_cnt != 4'h0) begin
					set[EVT_COL] = 1'b1;
				end else begin
					next_s.tx_hold = pwdata[7:0];
					next_s.tx_sh = s.cke ? pwdata[7:0] : {pwdata[6:0], 1'b0};
					if (!s.cke)
						next_s.sdo = pwdata[7];
				end
			end
		end
		// Data in lags two cycles in the synchroniser, so master strobes wait
		next_s.cap_dly = {s.cap_dly[0], mcap};
		next_s.fin_dly = {s.fin_dly[0], mfin};
		if (master) begin
			cap = s.cap_dly[1];
			fin = s.fin_dly[1];
		end
		if (master && wr_fire && paddr == DATA_ADDR) begin
			if (s.mode != ST_IDLE || s.fin_dly != 2'b00)
				set[EVT_COL] = 1'b1;
			else
				next_s.tx_hold = pwdata[7:0];
		end

		// MSB out first, new bits enter at the bottom
		if (chg) begin
			next_s.sdo = s.tx_sh[7];
			next_s.tx_sh = {s.tx_sh[6:0], 1'b0};
		end
		if (cap) begin
			next_s.rx_sh = {s.rx_sh[6:0], sdi_s};
			next_s.bit_cnt = s.bit_cnt + 4'h1;
		end
		if (fin) begin
			next_s.bit_cnt = '0;
			set[EVT_DONE] = 1'b1;
			if (s.full) begin
				// Old byte kept; software lost the new one
				set[EVT_OVR] = 1'b1;
			end else begin
				next_s.rx_buf = {s.rx_sh[6:0], sdi_s};
				if (!cap)
					next_s.rx_buf = s.rx_sh;
			end
		end
		// Reading the byte frees the buffer; a new byte wins
		if (rd_fire && paddr == DATA_ADDR)
			next_s.full = 1'b0;
		if (fin)
			next_s.full = 1'b1;

		next_s.evt = (s.evt & ~clr) | set;
		next_s.irq = |(next_s.evt & next_s.mask);
	end

	assign done = s.evt[EVT_DONE];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.ctrl <= CTRL_RESET;
			s.phase <= STAT_RESET[STAT_PHASE];
			s.cke <= STAT_RESET[STAT_CKE];
			s.mode <= ST_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign sck_out = s.sck_out;
	assign sck_oe = s.sck_oe;
	assign sdo = s.sdo;
	assign sdo_oe = s.sdo_oe;
	assign irq = s.irq;

	// ==========================================================
	// Checks
	a_idle_sck_level: assert property (
		@(posedge pclk) disable iff (!presetn)
		(s.mode == ST_IDLE && $past(s.mode) == ST_IDLE && $past(en))
		|-> s.sck_out == $past(s.ctrl[CTRL_CPOL]))
		else $error("clock line not at idle level");

	a_sck_rate: assert property (
		@(posedge pclk) disable iff (!presetn)
		($changed(s.sck_out) && $past(s.mode) == ST_SHIFT)
		|-> $past(s.div_cnt) == $past(half) - 6'h01)
		else $error("master clock edge off the divider tick");

	a_change_edge: assert property (
		@(posedge pclk) disable iff (!presetn)
		($changed(s.sdo) && $changed(s.sck_out) && $past(s.mode) == ST_SHIFT)
		|-> (s.sck_out != s.ctrl[CTRL_CPOL]) == s.cke)
		else $error("data changed on the wrong clock edge");

	a_master_drives: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(master) |-> s.sck_oe)
		else $error("master not driving the clock line");

	a_slave_clock_in: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(slave) |-> !s.sck_oe)
		else $error("slave driving the clock line");

	a_select_gates: assert property (
		@(posedge pclk) disable iff (!presetn)
		(slave && use_ss && ss_n_s) |=> !s.sdo_oe && s.bit_cnt == 4'h0)
		else $error("deselected slave still active");

	a_write_starts: assert property (
		@(posedge pclk) disable iff (!presetn)
		(master && s.mode == ST_IDLE && wr_fire && paddr == DATA_ADDR
		&& s.fin_dly == 2'b00)
		|=> s.mode == ST_SHIFT ##1 s.mode == ST_SHIFT)
		else $error("buffer write did not start a frame");

	a_eight_bits: assert property (
		@(posedge pclk) disable iff (!presetn)
		(master && s.fin_dly[1])
		|-> s.bit_cnt + 4'(s.cap_dly[1]) == FRAME_BITS)
		else $error("frame did not hold eight bits");

	a_buffer_full: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(done) |-> s.full)
		else $error("frame done without buffer full");

	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		s.irq == |(s.evt & s.mask))
		else $error("interrupt does not follow masked status");

endmodule : spi_port

// File: spi_peer.sv
`timescale 1ns/1ns
module spi_peer (
	// Line setup
	input wire logic cpol,
	input wire logic cke,
	// Serial lines
	input wire logic sck_line,
	input wire logic sdo_dev,
	output logic sck_drv,
	output logic sdi,
	output logic ss_n,
	// Bytes
	input wire logic [7:0] tx,
	output logic [7:0] rx,
	output int edges
);
	logic [7:0] sh;
	logic first;
	initial begin
		sck_drv = 1'b0;
		sdi = 1'b0;
		ss_n = 1'b1;
		rx = 8'h00;
		sh = 8'h00;
		first = 1'b1;
		edges = 0;
	end
	// ==========================================
	// Frame setup; the delay lets the idle level settle first
	task automatic arm();
		sck_drv = cpol;
		#1;
		sh = tx;
		first = 1'b1;
		edges = 0;
		sdi = tx[7];
	endtask : arm
	// ==========================================
	// Shift: change on one edge, sample on the other
	always @(sck_line) begin
		edges = edges + 1;
		if ((sck_line != cpol) == cke) begin
			if (cke && first)
				first = 1'b0;
			else
				sh = {sh[6:0], ~sh[0]};
			sdi = sh[7];
		end else begin
			rx = {rx[6:0], sdo_dev};
		end
	end
	// ==========================================
	// Master role: 125 ns clock only within the frame
	task automatic run();
		ss_n = 1'b0;
		#62;
		repeat (8) begin
			sck_drv = ~sck_drv;
			#62;
			sck_drv = ~sck_drv;
			#63;
		end
		ss_n = 1'b1;
		sdi = ~sdi;
	endtask : run
endmodule : spi_peer

// File: spi_port_tb.sv
`timescale 1ns/1ns
module spi_port_tb;
	import spi_port_pkg::*;
	typedef struct packed {
		logic rd;
		logic err;
		logic [31:0] d;
	} note_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, sck_out, sck_oe, sdo, sdo_oe, irq;
	logic sck_drv, sdi, ss_n, cpol, cke, phase, last;
	logic [7:0] ptx, dtx, p1;
	logic [7:0] prx;
	logic [5:0] half;
	int pedges, gap, run, fails, num_checks, seed;
	note_t notes[$];
	wire sck_line = sck_oe ? sck_out : sck_drv;
	initial begin
		cpol = 1'b0;
		cke = 1'b0;
		ptx = 8'h00;
		fails = 0;
		num_checks = 0;
		seed = 32'h7142334E;
	end
	always #2 pclk = ~pclk;
	spi_port i_spi_port (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sck_in(sck_line), .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi),
		.sdo(sdo), .sdo_oe(sdo_oe), .ss_n(ss_n), .irq(irq));
	spi_peer i_spi_peer (.cpol(cpol), .cke(cke), .sck_line(sck_line),
		.sdo_dev(sdo), .sck_drv(sck_drv), .sdi(sdi), .ss_n(ss_n), .tx(ptx),
		.rx(prx), .edges(pedges));
	// ==========================================
	// Checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			if (notes.size() == 0) begin
				check(32'h1, 32'h0);
			end else begin
				check(pslverr, notes[0].err);
				if (notes[0].rd)
					check(prdata, notes[0].d);
				void'(notes.pop_front());
			end
		end
	end
	// Clock line half period, in pclk cycles
	always @(posedge pclk) begin
		if (sck_line != last) begin
			gap <= run;
			run <= 1;
		end else begin
			run <= run + 1;
		end
		last <= sck_line;
	end
	// ==========================================
	// Bus and wait tasks
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, input logic [31:0] ed, input logic ee);
		int n;
		notes.push_back('{~wr, ee, ed});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			end_sim();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 5000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 5000) begin
			fails++;
			end_sim();
		end
	endtask : wait_irq
	task automatic setup(input logic [3:0] mode);
		// Park disabled first, so a new idle level is never taken as an edge
		apb(1'b1, CTRL_ADDR, {26'h0, 1'b0, cpol, mode}, 32'h0, 1'b0);
		ptx = $random(seed);
		dtx = $random(seed);
		i_spi_peer.arm();
		@(posedge pclk);
		apb(1'b1, STAT_ADDR, {24'h0, phase, cke, 6'h0}, 32'h0, 1'b0);
		apb(1'b1, CTRL_ADDR, {26'h0, 1'b1, cpol, mode}, 32'h0, 1'b0);
		repeat (3) @(posedge pclk);
	endtask : setup
	// ==========================================
	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, CTRL_ADDR, 32'h0, 32'h0, 1'b0);
		apb(1'b0, 8'hFC, 32'h0, 32'h0, 1'b1);
		apb(1'b1, STAT_ADDR, 32'hFF, 32'h0, 1'b0);
		apb(1'b0, STAT_ADDR, 32'hC0, 32'hC0, 1'b0);
		apb(1'b1, MASK_ADDR, 32'h1, 32'h0, 1'b0);
		for (int i = 0; i < 12; i++) begin
			cpol = (i / 3) % 2;
			cke = i / 6;
			phase = $random(seed);
			half = (i % 3 == 0) ? HALF_DIV4 : (i % 3 == 1) ? HALF_DIV16 : HALF_DIV64;
			setup(MODE_MASTER_DIV4 + 4'(i % 3));
			check(sck_line, cpol);
			check(sck_oe, 1'b1);
			check(sdo_oe, 1'b1);
			apb(1'b1, DATA_ADDR, {24'h0, dtx}, 32'h0, 1'b0);
			if (i == 0)
				apb(1'b1, DATA_ADDR, 32'h5A, 32'h0, 1'b0);
			wait_irq();
			check(pedges, 32'd16);
			check(gap, half);
			check(prx, dtx);
			apb(1'b0, EVT_ADDR, 32'h0, (i == 0) ? 32'h5 : 32'h1, 1'b0);
			apb(1'b0, STAT_ADDR, 32'h0, {24'h0, phase, cke, 6'h1}, 1'b0);
			check(irq, 1'b0);
			apb(1'b0, DATA_ADDR, 32'h0, {24'h0, ptx}, 1'b0);
			apb(1'b0, STAT_ADDR, 32'h0, {24'h0, phase, cke, 6'h0}, 1'b0);
		end
		// Overrun with the interrupt masked
		cpol = 1'b0;
		cke = 1'b0;
		phase = 1'b0;
		apb(1'b1, MASK_ADDR, 32'h0, 32'h0, 1'b0);
		setup(MODE_MASTER_DIV4);
		p1 = ptx;
		apb(1'b1, DATA_ADDR, {24'h0, dtx}, 32'h0, 1'b0);
		repeat (40) @(posedge pclk);
		check(irq, 1'b0);
		i_spi_peer.arm();
		@(posedge pclk);
		apb(1'b1, DATA_ADDR, {24'h0, dtx}, 32'h0, 1'b0);
		repeat (40) @(posedge pclk);
		apb(1'b1, MASK_ADDR, 32'h3, 32'h0, 1'b0);
		apb(1'b0, STAT_ADDR, 32'h0, 32'h1, 1'b0);
		check(irq, 1'b1);
		apb(1'b0, EVT_ADDR, 32'h0, 32'h3, 1'b0);
		apb(1'b0, DATA_ADDR, 32'h0, {24'h0, p1}, 1'b0);
		// Slave role, clock from the peer
		for (int i = 0; i < 4; i++) begin
			cpol = i % 2;
			cke = i / 2;
			phase = 1'b0;
			setup((i < 2) ? MODE_SLAVE_SS : MODE_SLAVE_NOSS);
			apb(1'b1, DATA_ADDR, {24'h0, dtx}, 32'h0, 1'b0);
			check(sck_oe, 1'b0);
			check(sdo_oe, i >= 2);
			i_spi_peer.run();
			@(posedge pclk);
			wait_irq();
			check(prx, dtx);
			apb(1'b0, EVT_ADDR, 32'h0, 32'h1, 1'b0);
			apb(1'b0, DATA_ADDR, 32'h0, {24'h0, ptx}, 1'b0);
		end
		end_sim();
	end
endmodule : spi_port_tb
